//--- hw/dsaf_top.v
/*
 * decoder store address former: looks up two decode arrays from the
 * instruction buffer and merges their words and instruction nibbles
 * into a nine-bit control-store address, with address-mode selection
 * and an axi4-lite slave for array access.
 * assumes the instruction buffer and microinstruction fields are
 * synchronous to ref_clk and stable for the microcycle.
 */
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dsaf_defines.vh"

// Functional notes
// - two separate decode arrays of sixteen 16-bit words set the mapping.
// - buffer bits 15..12 index the first array, bits 11..8 the second.
// - the two looked-up words are merged into a nine-bit next address.
// - decoding needs test select 00, sequence select 00, group code X1XX.
// - a pending interrupt suppresses decoding and selects interrupt mode.
// - special action 11X0 inhibits decoding and selects field addressing.
// - the low nine bits of the first word always form the base address.
// - second-word bits 8..4 are ORed in when first bit 12 or 15 is zero.
// - second-word bits 3..0 join if first bit 10 is set, 12 or 15 clear.
// - buffer 7..4 are ORed in if !first14, or !first15 and second13.
// - buffer 3..0 are ORed in if !first13, or !first15 and second13.
// - address bit 2 takes buffer bit 3, not 6, if first10 and second9 set.
// - decode word bits count from the right, bit zero least significant.
// - decode word bits 15..9 leave the block as class indications.
// - arrays are read-only unless the writable option is built and enabled.
module dsaf_top #(
  parameter         WRITABLE = 1,
  parameter [255:0] INIT_FIRST = 256'h0,
  parameter [255:0] INIT_SECOND = 256'h0
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [15:0] instr_buf,
  input  wire [1:0]  branch_test_select_field,
  input  wire [1:0]  sequence_select_field,
  input  wire [3:0]  group_code_field,
  input  wire [3:0]  special_action_field,
  input  wire        interrupt_pending,
  output wire [8:0]  decoded_addr,
  output wire [1:0]  addr_mode,
  output wire [6:0]  class_first,
  output wire [6:0]  class_second,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // byte-lane merge of a write into a stored word
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // nibble enable: a bit clear, or bit 15 clear with the partner bit set
  function nib_en;
    input own_bit;
    input f15;
    input s13;
    begin
      nib_en = ~own_bit | (~f15 & s13);
    end
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg         ctrl_wen_r;
  reg  [4:0]  sel_r;
  reg  [3:0]  aw_addr_r;
  reg         aw_got_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_got_r;
  wire        aw_hs;
  wire        w_hs;
  wire        ar_hs;
  wire        do_write;
  wire [3:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire [15:0] first_word;
  wire [15:0] second_word;
  wire [15:0] first_rd;
  wire [15:0] second_rd;
  wire [15:0] sel_rd;
  wire [31:0] data_merged;
  wire        arr_wr;
  wire        wr_first;
  wire        wr_second;
  reg  [8:0]  addr_c;
  reg  [3:0]  ib_hi_c;
  reg  [1:0]  mode_c;
  wire        dec_enable;
  wire        dec_inhibit;
  wire        hi_or_en;
  wire        lo_or_en;
  wire        ibhi_en;
  wire        iblo_en;
  reg  [31:0] rd_val_c;
  reg  [1:0]  rd_resp_c;

  // ****************************************************************
  // decode arrays
  // ****************************************************************

  // array writes only exist when the writable option is built in
  assign arr_wr    = (WRITABLE != 0) && ctrl_wen_r && do_write &&
                     (wr_addr == `DSAF_OFS_DATA);
  assign wr_first  = arr_wr && !sel_r[`DSAF_SEL_ARR_BIT];
  assign wr_second = arr_wr && sel_r[`DSAF_SEL_ARR_BIT];
  assign sel_rd    = sel_r[`DSAF_SEL_ARR_BIT] ? second_rd : first_rd;
  assign data_merged = lane_merge({16'h0000, sel_rd}, wr_data, wr_strb);

  // first array, indexed by the top nibble of the instruction
  dsaf_array #(
    .WORDS (16),
    .WIDTH (16),
    .INIT  (INIT_FIRST)
  ) u_first (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (wr_first),
    .wr_idx  (sel_r[3:0]),
    .wr_data (data_merged[15:0]),
    .lk_idx  (instr_buf[15:12]),
    .lk_word (first_word),
    .rd_idx  (sel_r[3:0]),
    .rd_word (first_rd)
  );

  // second array, indexed by the next nibble down
  dsaf_array #(
    .WORDS (16),
    .WIDTH (16),
    .INIT  (INIT_SECOND)
  ) u_second (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (wr_second),
    .wr_idx  (sel_r[3:0]),
    .wr_data (data_merged[15:0]),
    .lk_idx  (instr_buf[11:8]),
    .lk_word (second_word),
    .rd_idx  (sel_r[3:0]),
    .rd_word (second_rd)
  );

  // ****************************************************************
  // address forming
  // ****************************************************************

  // contribution enables, bit numbers counted from the right
  assign hi_or_en = ~first_word[`DSAF_F_HIOR_A_BIT] |
                    ~first_word[`DSAF_F_HIOR_B_BIT];
  assign lo_or_en = first_word[`DSAF_F_LOWOR_BIT] & hi_or_en;
  assign ibhi_en  = nib_en(first_word[`DSAF_F_IBHI_BIT],
                           first_word[`DSAF_F_HIOR_B_BIT],
                           second_word[`DSAF_S_IB_BIT]);
  assign iblo_en  = nib_en(first_word[`DSAF_F_IBLO_BIT],
                           first_word[`DSAF_F_HIOR_B_BIT],
                           second_word[`DSAF_S_IB_BIT]);

  // combinational merge of base word and enabled contributions
  always @* begin
    ib_hi_c = instr_buf[7:4];
    if (first_word[`DSAF_F_SWAP_BIT] && second_word[`DSAF_S_SWAP_BIT]) begin
      ib_hi_c[`DSAF_SWAP_ADDR_BIT] = instr_buf[3];
    end
    addr_c = first_word[`DSAF_BASE_MSB:0];
    if (hi_or_en) begin
      addr_c[`DSAF_BASE_MSB:`DSAF_HI_LSB] =
        addr_c[`DSAF_BASE_MSB:`DSAF_HI_LSB] |
        second_word[`DSAF_BASE_MSB:`DSAF_HI_LSB];
    end
    if (lo_or_en) begin
      addr_c[`DSAF_LO_MSB:0] = addr_c[`DSAF_LO_MSB:0] |
                               second_word[`DSAF_LO_MSB:0];
    end
    if (ibhi_en) begin
      addr_c[`DSAF_LO_MSB:0] = addr_c[`DSAF_LO_MSB:0] | ib_hi_c;
    end
    if (iblo_en) begin
      addr_c[`DSAF_LO_MSB:0] = addr_c[`DSAF_LO_MSB:0] |
                               instr_buf[3:0];
    end
  end

  // mode selection from the sequencing fields
  assign dec_enable  = (branch_test_select_field == `DSAF_TEST_SEL_DEC) &&
                       (sequence_select_field == `DSAF_SEQ_SEL_DEC) &&
                       group_code_field[`DSAF_GROUP_BIT];
  assign dec_inhibit = (special_action_field & `DSAF_ACT_INH_MASK) ==
                       `DSAF_ACT_INH_CODE;

  always @* begin
    if (interrupt_pending) begin
      mode_c = `DSAF_MODE_INTR;
    end else if (dec_enable && dec_inhibit) begin
      mode_c = `DSAF_MODE_FIELD;
    end else if (dec_enable) begin
      mode_c = `DSAF_MODE_DECODE;
    end else begin
      mode_c = `DSAF_MODE_OTHER;
    end
  end

  // same-cycle outputs towards the address selector
  assign decoded_addr = addr_c;
  assign addr_mode    = mode_c;
  assign class_first  = first_word[15:`DSAF_CLASS_LSB];
  assign class_second = second_word[15:`DSAF_CLASS_LSB];

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign aw_hs   = s_axi_awvalid && s_axi_awready;
  assign w_hs    = s_axi_wvalid && s_axi_wready;
  assign wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_got_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;
  assign do_write = (aw_got_r || aw_hs) && (w_got_r || w_hs) &&
                    !s_axi_bvalid;

  // address and data are held until both halves have arrived
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      aw_got_r  <= 1'b0;
      aw_addr_r <= 4'h0;
      w_got_r   <= 1'b0;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
    end else if (do_write) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // register updates and the write response
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_wen_r   <= `DSAF_CTRL_RST;
      sel_r        <= `DSAF_SEL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DSAF_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `DSAF_RESP_OKAY;
        case (wr_addr)
          `DSAF_OFS_CTRL: begin
            if (wr_strb[0]) begin
              ctrl_wen_r <= wr_data[`DSAF_CTRL_WEN_BIT];
            end
          end
          `DSAF_OFS_SEL: begin
            if (wr_strb[0]) begin
              sel_r <= wr_data[4:0];
            end
          end
          `DSAF_OFS_STATUS: begin
            s_axi_bresp <= `DSAF_RESP_OKAY; // read-only, write ignored
          end
          `DSAF_OFS_DATA: begin
            s_axi_bresp <= `DSAF_RESP_OKAY; // array port handles it
          end
          default: begin
            s_axi_bresp <= `DSAF_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  // read decode of the register map
  always @* begin
    rd_val_c  = 32'h00000000;
    rd_resp_c = `DSAF_RESP_OKAY;
    case (s_axi_araddr)
      `DSAF_OFS_CTRL:   rd_val_c[`DSAF_CTRL_WEN_BIT] = ctrl_wen_r;
      `DSAF_OFS_STATUS: rd_val_c[10:0] = {mode_c, addr_c};
      `DSAF_OFS_SEL:    rd_val_c[4:0] = sel_r;
      `DSAF_OFS_DATA:   rd_val_c[15:0] = sel_rd;
      default:          rd_resp_c = `DSAF_RESP_SLVERR;
    endcase
  end

  // read data registered one cycle after the address is taken
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `DSAF_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val_c;
      s_axi_rresp  <= rd_resp_c;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- inc/dsaf_defines.vh
/*
 * constants of the decoder store address former: register map, field
 * codes, decode word bit positions and address selection modes.
 * assumes inclusion by bare name from the design files.
 */
`ifndef DSAF_DEFINES_VH
`define DSAF_DEFINES_VH

// ****************************************************************
// register map (byte addresses, one word each)
// ****************************************************************
`define DSAF_OFS_CTRL      4'h0
`define DSAF_OFS_STATUS    4'h4
`define DSAF_OFS_SEL       4'h8
`define DSAF_OFS_DATA      4'hc
`define DSAF_CTRL_RST      1'h0
`define DSAF_SEL_RST       5'h00
`define DSAF_CTRL_WEN_BIT  0
`define DSAF_SEL_ARR_BIT   4
`define DSAF_RESP_OKAY     2'h0
`define DSAF_RESP_SLVERR   2'h2

// ****************************************************************
// microinstruction field codes
// ****************************************************************
`define DSAF_TEST_SEL_DEC  2'h0
`define DSAF_SEQ_SEL_DEC   2'h0
`define DSAF_GROUP_BIT     2
`define DSAF_ACT_INH_MASK  4'hd
`define DSAF_ACT_INH_CODE  4'hc

// ****************************************************************
// decode word bit positions
// ****************************************************************
`define DSAF_BASE_MSB      8
`define DSAF_HI_LSB        4
`define DSAF_LO_MSB        3
`define DSAF_F_LOWOR_BIT   10
`define DSAF_F_HIOR_A_BIT  12
`define DSAF_F_HIOR_B_BIT  15
`define DSAF_F_IBHI_BIT    14
`define DSAF_F_IBLO_BIT    13
`define DSAF_S_IB_BIT      13
`define DSAF_S_SWAP_BIT    9
`define DSAF_F_SWAP_BIT    10
`define DSAF_SWAP_ADDR_BIT 2
`define DSAF_CLASS_LSB     9

// ****************************************************************
// address selection modes
// ****************************************************************
`define DSAF_MODE_OTHER    2'h0
`define DSAF_MODE_DECODE   2'h1
`define DSAF_MODE_INTR     2'h2
`define DSAF_MODE_FIELD    2'h3

`endif

//--- hw/dsaf_array.v
/*
 * one decode array: sixteen words of sixteen bits in flip-flops, with
 * one lookup port, one software read port and one write port.
 * assumes the write port is gated by the owner when the array is
 * meant to be read-only.
 */
`timescale 1ns/1ps
`default_nettype none

module dsaf_array #(
  parameter        WORDS = 16,
  parameter        WIDTH = 16,
  parameter [255:0] INIT = 256'h0
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire             wr_en,
  input  wire [3:0]       wr_idx,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [3:0]       lk_idx,
  output wire [WIDTH-1:0] lk_word,
  input  wire [3:0]       rd_idx,
  output wire [WIDTH-1:0] rd_word
);

  reg [WIDTH-1:0] mem_r [0:WORDS-1];
  integer         i;

  // storage: contents come back from the init image on reset
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        mem_r[i] <= INIT[i*WIDTH +: WIDTH];
      end
    end else if (wr_en) begin
      mem_r[wr_idx] <= wr_data;
    end
  end

  // both read ports are plain indexed reads
  assign lk_word = mem_r[lk_idx];
  assign rd_word = mem_r[rd_idx];

endmodule

`default_nettype wire

//--- tb/dsaf_checker.sv
/* checker of dsaf_top: mode choice, nibble merges and bus answers.
   assumes it is bound to dsaf_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module dsaf_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [15:0] instr_buf,
  input wire logic [1:0]  branch_test_select_field,
  input wire logic [1:0]  sequence_select_field,
  input wire logic [3:0]  group_code_field,
  input wire logic [3:0]  special_action_field,
  input wire logic        interrupt_pending,
  input wire logic [8:0]  decoded_addr,
  input wire logic [1:0]  addr_mode,
  input wire logic [6:0]  class_first,
  input wire logic [6:0]  class_second,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  // ****************************************************************
  // enable terms and relations
  // ****************************************************************
  wire en;
  wire inh;
  wire swp;
  // decode enable, inhibit code and bit-2 swap condition
  assign en = branch_test_select_field == 2'h0 &&
              sequence_select_field == 2'h0 && group_code_field[2];
  assign inh = (special_action_field & 4'hd) == 4'hc;
  assign swp = class_first[1] && class_second[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_intr_mode:
    assert property (interrupt_pending |-> addr_mode == 2'h2)
    else $error("interrupt addressing not chosen");
  a_field_mode:
    assert property (!interrupt_pending && en && inh |-> addr_mode == 2'h3)
    else $error("field addressing not chosen");
  a_decode_mode:
    assert property (!interrupt_pending && en && !inh |-> addr_mode == 2'h1)
    else $error("decoder addressing not chosen");
  a_idle_mode:
    assert property (!interrupt_pending && !en |-> addr_mode == 2'h0)
    else $error("decoder addressing chosen while disabled");
  a_ib_high_or:
    assert property (!class_first[5] && !swp |->
      (decoded_addr[3:0] & instr_buf[7:4]) == instr_buf[7:4])
    else $error("upper instruction nibble not merged");
  a_ib_low_or:
    assert property (!class_first[4] |->
      (decoded_addr[3:0] & instr_buf[3:0]) == instr_buf[3:0])
    else $error("lower instruction nibble not merged");
  a_swap_bit:
    assert property (!class_first[5] && swp && instr_buf[3] |->
      decoded_addr[2])
    else $error("address bit 2 swap missing");
  a_addr_stable:
    assert property (!s_axi_bvalid && $stable(instr_buf) |->
      $stable(decoded_addr))
    else $error("formed address moved with steady inputs");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  c_field: cover property (!interrupt_pending && en && inh);
  c_intr: cover property (addr_mode == 2'h2);
  c_swap: cover property (!class_first[5] && swp && instr_buf[3]);
endmodule
bind dsaf_top dsaf_checker u_chk (
  .ref_clk(ref_clk), .reset(reset), .instr_buf(instr_buf),
  .branch_test_select_field(branch_test_select_field),
  .sequence_select_field(sequence_select_field),
  .group_code_field(group_code_field),
  .special_action_field(special_action_field),
  .interrupt_pending(interrupt_pending), .decoded_addr(decoded_addr),
  .addr_mode(addr_mode), .class_first(class_first),
  .class_second(class_second), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

//--- tb/dsaf_seq_model.sv
/* microsequencer model: picks the next control-store address by mode.
   assumes mode and formed address settle within the microcycle. */
`timescale 1ns/1ps
`default_nettype none
module dsaf_seq_model #(
  parameter [8:0] INTR_ADDR = 9'h100
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [8:0] decoded_addr,
  input  wire logic [1:0] addr_mode,
  input  wire logic [8:0] field_addr,
  output var  logic [8:0] next_addr_r
);
  // ****************************************************************
  // address selector
  // ****************************************************************
  // other mode simply steps on, so a stuck mode shows as a count
  always @(posedge ref_clk or posedge reset) begin
    if (reset) next_addr_r <= 9'h000;
    else if (addr_mode == 2'h1) next_addr_r <= decoded_addr;
    else if (addr_mode == 2'h2) next_addr_r <= INTR_ADDR;
    else if (addr_mode == 2'h3) next_addr_r <= field_addr;
    else next_addr_r <= next_addr_r + 9'h001;
  end
endmodule
`default_nettype wire

//--- tb/dsaf_top_bench.sv
/* bench of dsaf_top: loads both decode arrays over axi4-lite, then
   checks formed address, mode and class bits against a reference.
   assumes dsaf_top, dsaf_seq_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module dsaf_top_bench;
  logic        ref_clk = 1'b0, reset = 1'b1, intr = 1'b0;
  logic [15:0] instr_buf = 16'h0000;
  logic [1:0]  test_sel = 2'h0, seq_sel = 2'h0;
  logic [3:0]  grp = 4'h0, spc = 4'h0, awaddr = 4'h0, araddr = 4'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, w, r, e, x_w;
  logic [9:0]  nx_exp = 10'h000;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        chk_on = 1'b0;
  wire  [8:0]  daddr, nxt;
  wire  [6:0]  cl_f, cl_s;
  wire  [1:0]  mode, bresp, rresp;
  wire  [31:0] rdata;
  wire         awready, wready, bvalid, arready, rvalid;
  logic [15:0] fa [16];
  logic [15:0] sa [16];
  logic [31:0] exp_dec [$];
  logic [33:0] exp_bus [$];
  integer      num_errors = 0, n_tests = 0, seed = 33, cyc = 0, i;

  always #50 ref_clk = ~ref_clk;

  dsaf_top #(.WRITABLE(1)) dut (
    .ref_clk(ref_clk), .reset(reset), .instr_buf(instr_buf),
    .branch_test_select_field(test_sel), .sequence_select_field(seq_sel),
    .group_code_field(grp), .special_action_field(spc),
    .interrupt_pending(intr), .decoded_addr(daddr), .addr_mode(mode),
    .class_first(cl_f), .class_second(cl_s), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  dsaf_seq_model seq (.ref_clk(ref_clk), .reset(reset),
    .decoded_addr(daddr), .addr_mode(mode), .field_addr(instr_buf[8:0]),
    .next_addr_r(nxt));

  // ****************************************************************
  // compares, verdict and reference
  // ****************************************************************
  task chk_bus(input logic [33:0] x, input logic [33:0] g);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch bus t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task chk_dec(input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch decode t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // expected {class_first, class_second, mode, address}
  function logic [31:0] model(input logic [31:0] v);
    logic [15:0] f, s;
    logic [8:0]  a;
    logic [3:0]  h;
    logic [1:0]  m;
    begin
      f = fa[v[15:12]];
      s = sa[v[11:8]];
      a = f[8:0];
      if (!f[12] || !f[15]) a[8:4] = a[8:4] | s[8:4];
      if (f[10] && (!f[12] || !f[15])) a[3:0] = a[3:0] | s[3:0];
      h = v[7:4];
      if (f[10] && s[9]) h[2] = v[3];
      if (!f[14] || (!f[15] && s[13])) a[3:0] = a[3:0] | h;
      if (!f[13] || (!f[15] && s[13])) a[3:0] = a[3:0] | v[3:0];
      m = (v[31] & v[30]) ? 2'h2 :
          !(v[17:16] == 2'h0 && v[20:19] == 2'h0 && v[24]) ? 2'h0 :
          ((v[29:26] & 4'hd) == 4'hc) ? 2'h3 : 2'h1;
      model = {7'h0, f[15:9], s[15:9], m, a};
    end
  endfunction

  // ****************************************************************
  // bus master tasks
  // ****************************************************************
  task wr(input logic [3:0] a, input logic [31:0] d,
          input logic [3:0] st, input logic [1:0] er);
    logic aw_ok, w_ok;
    begin
      @(posedge ref_clk);
      exp_bus.push_back({er, 32'h0});
      awaddr <= a; wdata <= d; wstrb <= st;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      aw_ok = 1'b0; w_ok = 1'b0;
      do begin
        @(posedge ref_clk);
        if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
        if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
      end while (!(aw_ok && w_ok));
      while (!bvalid) @(posedge ref_clk);
      bready <= 1'b0;
    end
  endtask
  task rd(input logic [3:0] a, input logic [33:0] x);
    begin
      @(posedge ref_clk);
      exp_bus.push_back(x);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge ref_clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge ref_clk);
      rready <= 1'b0;
    end
  endtask

  // watcher: oldest note against each result, plus hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (bvalid && bready) chk_bus(exp_bus.pop_front(), {bresp, 32'h0});
    if (rvalid && rready) chk_bus(exp_bus.pop_front(), {rresp, rdata});
    if (nx_exp[9]) chk_dec({23'h0, nx_exp[8:0]}, {23'h0, nxt});
    nx_exp = 10'h000;
    if (chk_on) begin
      x_w = exp_dec.pop_front();
      chk_dec(x_w, {7'h0, cl_f, cl_s, mode, daddr});
      // the partner must then take the decoded, interrupt or field address
      case (x_w[10:9])
        2'h1: nx_exp = {1'b1, x_w[8:0]};
        2'h2: nx_exp = 10'h300;
        2'h3: nx_exp = {1'b1, instr_buf[8:0]};
        default: nx_exp = 10'h000;
      endcase
    end
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end

  // reset, array load over the bus, then random decode sweep
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h0, 34'h0);
    rd(4'h8, 34'h0);
    rd(4'h2, {2'h2, 32'h0});
    wr(4'h2, 32'h1, 4'hf, 2'h2);
    wr(4'hc, 32'hffff, 4'hf, 2'h0);
    rd(4'hc, 34'h0);
    wr(4'h0, 32'h1, 4'hf, 2'h0);
    for (i = 0; i < 32; i++) begin
      w = $random(seed);
      wr(4'h8, i, 4'hf, 2'h0);
      wr(4'hc, w, 4'hf, 2'h0);
      if (i < 16) fa[i] = w[15:0];
      else sa[i - 16] = w[15:0];
    end
    wr(4'hc, 32'h5a5a, 4'h1, 2'h0);
    sa[15][7:0] = 8'h5a;
    rd(4'hc, {18'h0, sa[15]});
    rd(4'h8, {2'h0, 32'h1f});
    for (i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      r = $random(seed);
      r[17] = r[17] & r[16];
      r[20] = r[20] & r[19];
      instr_buf <= r[15:0];
      test_sel <= r[17:16] ^ {1'b0, r[17]};
      seq_sel <= r[20:19] ^ {1'b0, r[20]};
      grp <= r[25:22]; spc <= r[29:26]; intr <= r[31] & r[30];
      r[16] = r[17] ^ r[16];
      r[19] = r[20] ^ r[19];
      r[24] = r[24];
      e = model(r);
      exp_dec.push_back(e);
      chk_on <= 1'b1;
    end
    @(posedge ref_clk);
    chk_on <= 1'b0;
    rd(4'h4, {23'h0, e[10:0]});
    summarize();
  end
endmodule
`default_nettype wire
